// file: verilog/blank_burst_pkg.sv
// Constants, types and register map of the protection blanking and burst select block.
// What this block does
// - A fault or low feedback must persist 20 ms before burst or auto restart.
// - Two blanking variants: fixed 20 ms only, or extendable by an external capacitor.
// - Only overload auto restart uses extension; other paths keep the fixed period.
// - In extendable mode the gate stays blocked at 20 ms until extension completes.
// - After 20 ms, enable the extension counter and close the charge switch.
// - At the upper comparator, count one, open charge and close discharge switch.
// - At the lower comparator, open discharge and close charge switch again.
// - Cycling repeats until the count reaches 256, then completion goes high.
// - With blanking expired and extension complete, wait 30 us, then auto restart.
// - Four burst entry levels: 10, 6.67, 4.38 and 0 percent of maximum power.
// - Each entry level pairs with exit level 20, 13.3, 9.6 or 0 percent.
// - One selection disables burst mode entirely.
// - Burst timer held at zero normally, counts while feedback low, enters after 20 ms.
// - Level chosen by counting feedback cycles in first 1 ms after power-on only.
`default_nettype none
package blank_burst_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ        = 25_000_000;
	localparam int BLANK_MS      = 20;
	localparam int SPIKE_US      = 30;
	localparam int SEL_WINDOW_MS = 1;
	localparam int BLANK_CYC     = CLK_HZ / 1000 * BLANK_MS;
	localparam int SPIKE_CYC     = CLK_HZ / 1_000_000 * SPIKE_US;
	localparam int SEL_CYC       = CLK_HZ / 1000 * SEL_WINDOW_MS;

	// ****************************************
	// Extension and level selection
	// ****************************************
	localparam int         EXT_CNT_W = 9;
	localparam logic [8:0] EXT_TOTAL = 9'h100;
	localparam int         SEL_CNT_W = 8;
	// Fewer feedback cycles mean a larger select capacitor and a higher entry level.
	localparam logic [7:0] SEL_TH_6P67 = 8'h04;
	localparam logic [7:0] SEL_TH_4P38 = 8'h10;
	localparam logic [7:0] SEL_TH_OFF  = 8'h40;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_EXT_COUNT  = 8'h08;
	localparam logic [7:0] REG_SEL_COUNT  = 8'h0C;
	localparam logic [7:0] REG_INT_STATUS = 8'h10;
	localparam logic [7:0] REG_INT_MASK   = 8'h14;
	localparam int CTRL_EXTEND_EN   = 0;
	localparam int CTRL_BURST_ALLOW = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam int ST_BURST  = 8;
	localparam int ST_LEVEL  = 9;
	localparam int ST_VALID  = 11;
	localparam int ST_RESTART = 12;
	localparam int IRQ_W           = 5;
	localparam int IRQ_BURST_ENTER = 0;
	localparam int IRQ_BURST_EXIT  = 1;
	localparam int IRQ_EXT_DONE    = 2;
	localparam int IRQ_RESTART     = 3;
	localparam int IRQ_LEVEL       = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [5:0] {
		OVL_IDLE    = 6'h01,
		OVL_BLANK   = 6'h02,
		OVL_CHARGE  = 6'h04,
		OVL_DISCH   = 6'h08,
		OVL_SPIKE   = 6'h10,
		OVL_RESTART = 6'h20
	} ovl_state_t;

	typedef enum logic [2:0] {
		SEL_WAIT = 3'h1,
		SEL_RUN  = 3'h2,
		SEL_DONE = 3'h4
	} sel_state_t;

	typedef enum logic [1:0] {
		LVL_10   = 2'h0,
		LVL_6P67 = 2'h1,
		LVL_4P38 = 2'h2,
		LVL_OFF  = 2'h3
	} burst_level_t;

	typedef struct packed {
		logic ext_upper;
		logic ext_lower;
		logic sel_upper;
		logic sel_lower;
		logic fb_below_entry;
		logic fb_above_exit;
	} cmp_t;

	typedef struct packed {
		logic extension_charge_switch;
		logic extension_discharge_switch;
		logic select_discharge_switch;
	} switch_t;
endpackage
`default_nettype wire

// file: verilog/input_sync.sv
// Two-stage synchroniser for a bundle of comparator levels.
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.meta   = d_i;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_o = s_r.stable;
endmodule
`default_nettype wire

// file: verilog/interval_timer.sv
// Saturating interval timer: cleared while idle, done after CYCLES running cycles.
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
	parameter int CYCLES = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	output logic      done_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
	} timer_state_t;

	timer_state_t s_r;
	timer_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!run_i) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt != LAST) begin
			s_nxt.cnt = s_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done_o = run_i && (s_r.cnt == LAST);
endmodule
`default_nettype wire

// file: verilog/protection_blanking_and_burst_select.sv
// Blanking, extension cycling, auto restart request and burst level control with Wishbone registers.
`timescale 1ns/1ps
`default_nettype none
module protection_blanking_and_burst_select #(
	parameter int BLANK_CYCLES = blank_burst_pkg::BLANK_CYC,
	parameter int SEL_CYCLES   = blank_burst_pkg::SEL_CYC
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	input  wire blank_burst_pkg::cmp_t         cmp_i,
	input  wire logic                          overload_fault_i,
	input  wire logic                          other_fault_i,
	output blank_burst_pkg::switch_t           sw_o,
	output logic                               burst_active_o,
	output blank_burst_pkg::burst_level_t      burst_level_o,
	output logic                               auto_restart_o,
	output logic                               irq_o
);
	import blank_burst_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ovl_state_t            ovl;
		logic [EXT_CNT_W-1:0]  ext_cnt;
		logic                  ext_chg;
		logic                  ext_dis;
		logic                  ext_done;
		sel_state_t            sel;
		logic [SEL_CNT_W-1:0]  sel_cnt;
		logic                  sel_dis;
		burst_level_t          level;
		logic                  level_valid;
		logic                  burst_act;
		logic                  restart;
		logic [1:0]            ctrl;
		logic [IRQ_W-1:0]      irq_stat;
		logic [IRQ_W-1:0]      irq_mask;
		logic                  irq;
		logic                  wb_ack;
		logic [31:0]           wb_dat;
	} blk_state_t;

	blk_state_t s_r;
	blk_state_t s_nxt;

	function automatic burst_level_t level_from_count(input logic [SEL_CNT_W-1:0] c);
		burst_level_t l;
		if (c >= SEL_TH_OFF) begin
			l = LVL_OFF;
		end else if (c >= SEL_TH_4P38) begin
			l = LVL_4P38;
		end else if (c >= SEL_TH_6P67) begin
			l = LVL_6P67;
		end else begin
			l = LVL_10;
		end
		return l;
	endfunction

	// ****************************************
	// Synchronised comparators and timers
	// ****************************************
	cmp_t cmp_s;
	logic [$bits(cmp_t)-1:0] cmp_raw_s;

	input_sync #(
		.W ($bits(cmp_t))
	) u_cmp_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (cmp_i),
		.q_o   (cmp_raw_s)
	);
	assign cmp_s = cmp_t'(cmp_raw_s);

	logic ovl_blank_done;
	logic other_blank_done;
	logic burst_blank_done;
	logic spike_done;
	logic sel_window_done;
	logic burst_run;

	interval_timer #(.CYCLES (BLANK_CYCLES)) u_ovl_blank (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (s_r.ovl == OVL_BLANK),
		.done_o (ovl_blank_done)
	);
	interval_timer #(.CYCLES (BLANK_CYCLES)) u_other_blank (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (other_fault_i),
		.done_o (other_blank_done)
	);
	interval_timer #(.CYCLES (BLANK_CYCLES)) u_burst_blank (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (burst_run),
		.done_o (burst_blank_done)
	);
	interval_timer #(.CYCLES (SPIKE_CYC)) u_spike (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (s_r.ovl == OVL_SPIKE),
		.done_o (spike_done)
	);
	interval_timer #(.CYCLES (SEL_CYCLES)) u_sel_window (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (s_r.sel == SEL_RUN),
		.done_o (sel_window_done)
	);

	// The burst timer only runs while entry is possible, so it sits at zero otherwise.
	assign burst_run = cmp_s.fb_below_entry && !s_r.burst_act && s_r.level_valid
		&& (s_r.level != LVL_OFF) && s_r.ctrl[CTRL_BURST_ALLOW];

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic             acc;
		logic [IRQ_W-1:0] ev;
		logic [7:0]       adr;
		s_nxt = s_r;
		ev    = '0;
		acc   = wb_cyc_i && wb_stb_i && !s_r.wb_ack;
		adr   = {wb_adr_i[7:2], 2'b00};

		// Overload path with optional extension.
		case (s_r.ovl)
			OVL_IDLE: begin
				if (overload_fault_i) begin
					s_nxt.ovl = OVL_BLANK;
				end
			end
			OVL_BLANK: begin
				if (ovl_blank_done) begin
					if (s_r.ctrl[CTRL_EXTEND_EN]) begin
						s_nxt.ovl     = OVL_CHARGE;
						s_nxt.ext_chg = 1'b1;
					end else begin
						s_nxt.ovl = OVL_SPIKE;
					end
				end
			end
			OVL_CHARGE: begin
				if (cmp_s.ext_upper) begin
					s_nxt.ext_cnt = s_r.ext_cnt + EXT_CNT_W'(1);
					s_nxt.ext_chg = 1'b0;
					if (s_r.ext_cnt + EXT_CNT_W'(1) == EXT_TOTAL) begin
						s_nxt.ext_done = 1'b1;
						s_nxt.ovl      = OVL_SPIKE;
						ev[IRQ_EXT_DONE] = 1'b1;
					end else begin
						s_nxt.ext_dis = 1'b1;
						s_nxt.ovl     = OVL_DISCH;
					end
				end
			end
			OVL_DISCH: begin
				if (cmp_s.ext_lower) begin
					s_nxt.ext_dis = 1'b0;
					s_nxt.ext_chg = 1'b1;
					s_nxt.ovl     = OVL_CHARGE;
				end
			end
			OVL_SPIKE: begin
				if (spike_done) begin
					s_nxt.ovl = OVL_RESTART;
					ev[IRQ_RESTART] = 1'b1;
				end
			end
			OVL_RESTART: begin
				s_nxt.ovl = OVL_RESTART;
			end
			default: begin
				s_nxt.ovl = OVL_IDLE;
			end
		endcase
		if (!overload_fault_i) begin
			s_nxt.ovl      = OVL_IDLE;
			s_nxt.ext_cnt  = '0;
			s_nxt.ext_chg  = 1'b0;
			s_nxt.ext_dis  = 1'b0;
			s_nxt.ext_done = 1'b0;
		end
		// Other protections restart after the fixed period only.
		if (other_blank_done && !s_r.restart && (s_r.ovl != OVL_RESTART)) begin
			ev[IRQ_RESTART] = 1'b1;
		end
		s_nxt.restart = (s_nxt.ovl == OVL_RESTART) || other_blank_done;

		// Level selection runs once per power-on reset; restarts do not reset this block.
		case (s_r.sel)
			SEL_WAIT: begin
				if (!other_fault_i) begin
					s_nxt.sel = SEL_RUN;
				end
			end
			SEL_RUN: begin
				if (cmp_s.sel_upper && !s_r.sel_dis) begin
					s_nxt.sel_dis = 1'b1;
					if (s_r.sel_cnt != '1) begin
						s_nxt.sel_cnt = s_r.sel_cnt + SEL_CNT_W'(1);
					end
				end else if (cmp_s.sel_lower && s_r.sel_dis) begin
					s_nxt.sel_dis = 1'b0;
				end
				if (sel_window_done) begin
					s_nxt.sel         = SEL_DONE;
					s_nxt.sel_dis     = 1'b0;
					s_nxt.level       = level_from_count(s_r.sel_cnt);
					s_nxt.level_valid = 1'b1;
					ev[IRQ_LEVEL]     = 1'b1;
				end
			end
			SEL_DONE: begin
				s_nxt.sel = SEL_DONE;
			end
			default: begin
				s_nxt.sel = SEL_WAIT;
			end
		endcase

		// Burst entry and exit.
		if (s_r.burst_act) begin
			if (cmp_s.fb_above_exit || !s_r.ctrl[CTRL_BURST_ALLOW] || (s_r.level == LVL_OFF)) begin
				s_nxt.burst_act = 1'b0;
				ev[IRQ_BURST_EXIT] = 1'b1;
			end
		end else if (burst_blank_done) begin
			s_nxt.burst_act = 1'b1;
			ev[IRQ_BURST_ENTER] = 1'b1;
		end

		// Register bus: registered ack, one wait state, unmapped reads return zero.
		s_nxt.wb_ack = acc;
		if (acc && !wb_we_i) begin
			case (adr)
				REG_CTRL:       s_nxt.wb_dat = {30'h0, s_r.ctrl};
				REG_STATUS:     s_nxt.wb_dat = {19'h0, s_r.restart, s_r.level_valid, s_r.level,
					s_r.burst_act, 2'h0, s_r.ovl};
				REG_EXT_COUNT:  s_nxt.wb_dat = {23'h0, s_r.ext_cnt};
				REG_SEL_COUNT:  s_nxt.wb_dat = {24'h0, s_r.sel_cnt};
				REG_INT_STATUS: s_nxt.wb_dat = {27'h0, s_r.irq_stat};
				REG_INT_MASK:   s_nxt.wb_dat = {27'h0, s_r.irq_mask};
				default:        s_nxt.wb_dat = 32'h0;
			endcase
		end
		if (acc && wb_we_i && wb_sel_i[0]) begin
			case (adr)
				REG_CTRL:       s_nxt.ctrl = wb_dat_i[1:0];
				REG_INT_STATUS: s_nxt.irq_stat = s_r.irq_stat & ~wb_dat_i[IRQ_W-1:0];
				REG_INT_MASK:   s_nxt.irq_mask = wb_dat_i[IRQ_W-1:0];
				default:        s_nxt.wb_dat = s_r.wb_dat;
			endcase
		end
		// A new event in the clearing cycle wins over the clear.
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
		s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r          <= '0;
			s_r.ovl      <= OVL_IDLE;
			s_r.sel      <= SEL_WAIT;
			s_r.level    <= LVL_10;
			s_r.ctrl     <= CTRL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_dat_o       = s_r.wb_dat;
	assign wb_ack_o       = s_r.wb_ack;
	assign sw_o           = '{extension_charge_switch: s_r.ext_chg,
		extension_discharge_switch: s_r.ext_dis, select_discharge_switch: s_r.sel_dis};
	assign burst_active_o = s_r.burst_act;
	assign burst_level_o  = s_r.level;
	assign auto_restart_o = s_r.restart;
	assign irq_o          = s_r.irq;
endmodule
`default_nettype wire

// file: bench/blank_burst_props.sv
// Concurrent checks on the blanking, extension and burst outputs.
`timescale 1ns/1ps
`default_nettype none
module blank_burst_props
	import blank_burst_pkg::*;
#(
	parameter int BLANK_CYCLES = 40,
	parameter int SEL_CYCLES   = 200
) (
	input wire logic         clk_i,
	input wire logic         rst_i,
	input wire cmp_t         cmp_i,
	input wire logic         overload_fault_i,
	input wire logic         other_fault_i,
	input wire switch_t      sw_o,
	input wire logic         burst_active_o,
	input wire burst_level_t burst_level_o,
	input wire logic         auto_restart_o
);
	// Run lengths of the causes, so that outcomes can be tied to how long a cause persisted.
	int fault_r;
	int low_r;
	int open_r;
	int up_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_r <= 0;
			low_r   <= 0;
			open_r  <= 0;
			up_r    <= 0;
		end else begin
			fault_r <= (overload_fault_i || other_fault_i) ? fault_r + 1 : 0;
			low_r   <= cmp_i.fb_below_entry ? low_r + 1 : 0;
			open_r  <= (sw_o.extension_charge_switch || sw_o.extension_discharge_switch) ? 0 : open_r + 1;
			up_r    <= (up_r < SEL_CYCLES + 8) ? up_r + 1 : up_r;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_upper_seen;
		(sw_o.extension_charge_switch && cmp_i.ext_upper && overload_fault_i) [*3];
	endsequence
	sequence s_lower_seen;
		(sw_o.extension_discharge_switch && cmp_i.ext_lower && overload_fault_i) [*3];
	endsequence

	a_switch_exclusive: assert property (!(sw_o.extension_charge_switch && sw_o.extension_discharge_switch))
		else $error("charge and discharge switches closed together");
	a_discharge_follows: assert property ($rose(sw_o.extension_discharge_switch) |-> $past(sw_o.extension_charge_switch))
		else $error("discharge closed without a charge phase");
	a_upper_counts: assert property (s_upper_seen |-> ##[0:2] !sw_o.extension_charge_switch)
		else $error("charge switch stayed closed at upper level");
	a_lower_recharge: assert property (s_lower_seen |-> ##[0:2] sw_o.extension_charge_switch)
		else $error("charge switch not closed at lower level");
	a_fault_clears: assert property (!overload_fault_i |=> !sw_o.extension_charge_switch && !sw_o.extension_discharge_switch)
		else $error("switches not cleared after fault removal");
	a_restart_blanked: assert property ($rose(auto_restart_o) |-> fault_r >= BLANK_CYCLES)
		else $error("restart before the blanking period");
	a_restart_spike: assert property ($rose(auto_restart_o) |-> open_r >= SPIKE_CYC)
		else $error("restart without the spike blanking interval");
	a_burst_blanked: assert property ($rose(burst_active_o) |-> low_r >= BLANK_CYCLES)
		else $error("burst entered before the blanking period");
	a_burst_never_off: assert property (burst_active_o |-> burst_level_o != LVL_OFF)
		else $error("burst active with burst disabled");
	a_level_once: assert property ($changed(burst_level_o) |-> up_r < SEL_CYCLES + 8)
		else $error("burst level changed after the selection window");
endmodule

bind protection_blanking_and_burst_select blank_burst_props #(
	.BLANK_CYCLES(BLANK_CYCLES),
	.SEL_CYCLES  (SEL_CYCLES)
) u_props (
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.cmp_i           (cmp_i),
	.overload_fault_i(overload_fault_i),
	.other_fault_i   (other_fault_i),
	.sw_o            (sw_o),
	.burst_active_o  (burst_active_o),
	.burst_level_o   (burst_level_o),
	.auto_restart_o  (auto_restart_o)
);
`default_nettype wire

// file: bench/cap_model.sv
// Behavioural model of the timing capacitors and their comparators.
`timescale 1ns/1ps
`default_nettype none
module cap_model
	import blank_burst_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire switch_t    sw_i,
	input  wire logic [9:0] ext_ticks_i,
	input  wire logic [9:0] sel_ticks_i,
	input  wire logic       fb_low_i,
	input  wire logic       fb_high_i,
	output var  cmp_t       cmp_o
);
	logic [9:0] ext_r;
	logic [9:0] sel_r;
	// The extension capacitor holds its charge with both switches open; the select one charges unless discharged; the ticks set how slow the far side is.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_r <= 10'h000;
			sel_r <= 10'h000;
		end else begin
			if (sw_i.extension_discharge_switch)
				ext_r <= 10'h000;
			else if (sw_i.extension_charge_switch && ext_r < ext_ticks_i)
				ext_r <= ext_r + 10'h001;
			if (sw_i.select_discharge_switch)
				sel_r <= 10'h000;
			else if (sel_r < sel_ticks_i)
				sel_r <= sel_r + 10'h001;
		end
	end
	assign cmp_o = '{ext_upper: ext_r >= ext_ticks_i, ext_lower: ext_r == 10'h000, sel_upper: sel_r >= sel_ticks_i,
		sel_lower: sel_r == 10'h000, fb_below_entry: fb_low_i, fb_above_exit: fb_high_i};
endmodule
`default_nettype wire

// file: bench/test_protection_blanking_and_burst_select.sv
// Self-checking bench for the blanking, extension and burst select block.
`timescale 1ns/1ps
`default_nettype none
module test_protection_blanking_and_burst_select;
	import blank_burst_pkg::*;
	localparam int BLANK = 40;
	localparam int SEL   = 2000;
	localparam logic [9:0] TK [4] = '{10'h00F, 10'h032, 10'h0C8, 10'h2BC};
	logic         clk, rst, cyc, stb, we, ack, ovl, oth, fb_low, fb_high, burst, restart, irq;
	logic [7:0]   adr;
	logic [31:0]  wdat, rdat, q;
	logic [9:0]   ext_ticks, sel_ticks;
	cmp_t         cmp;
	switch_t      sw;
	burst_level_t lvl;
	int           failures, samples_checked, n, chg;

	always #20 clk = ~clk;

	protection_blanking_and_burst_select #(.BLANK_CYCLES(BLANK), .SEL_CYCLES(SEL)) DUT (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmp_i(cmp),
		.overload_fault_i(ovl), .other_fault_i(oth), .sw_o(sw), .burst_active_o(burst),
		.burst_level_o(lvl), .auto_restart_o(restart), .irq_o(irq));
	cap_model model (.clk_i(clk), .rst_i(rst), .sw_i(sw), .ext_ticks_i(ext_ticks), .sel_ticks_i(sel_ticks),
		.fb_low_i(fb_low), .fb_high_i(fb_high), .cmp_o(cmp));

	task automatic test_done;
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0;
		if (k >= 50) begin
			failures++;
			test_done();
		end
		@(posedge clk);
	endtask
	// Waits for the restart request, counting closures of the charge switch on the way.
	task automatic run_until(input int lim);
		logic p;
		p = 1'b0; n = 0; chg = 0;
		while (restart !== 1'b1) begin
			@(posedge clk);
			n++;
			if (sw.extension_charge_switch === 1'b1 && !p) chg++;
			p = sw.extension_charge_switch;
			if (n > lim) begin
				failures++;
				test_done();
			end
		end
	endtask

	initial begin
		clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00; wdat = 32'h0; ovl = 0; oth = 0;
		fb_low = 0; fb_high = 0; ext_ticks = 10'h008; sel_ticks = 10'h00F; failures = 0; samples_checked = 0;
		tick(12);
		rst <= 1'b0;
		bus(0, REG_CTRL, 0);   chk(q, 32'(CTRL_RESET));
		bus(0, REG_INT_MASK, 0); chk(q, 32'h0);
		bus(0, 8'h20, 0);      chk(q, 32'h0);
		bus(1, REG_EXT_COUNT, 32'h1FF); bus(0, REG_EXT_COUNT, 0); chk(q, 32'h0);
		$display("reset test ended");
		for (int i = 0; i < 4; i++) begin
			sel_ticks <= TK[i]; rst <= 1'b1; tick(12); rst <= 1'b0;
			tick(SEL + 20);
			chk(32'(lvl), 32'(3 - i));
			bus(0, REG_STATUS, 0); chk(32'(q[11:9]), 32'(4 + 3 - i));
			fb_low <= 1'b1; tick(BLANK - 4);
			chk(32'(burst), 32'h0);
			tick(30);
			chk(32'(burst), 32'(i != 0));
			fb_low <= 1'b0; fb_high <= 1'b1; tick(6);
			chk(32'(burst), 32'h0);
			fb_high <= 1'b0;
		end
		$display("level test ended");
		ovl <= 1'b1; tick(20); ovl <= 1'b0; tick(2); ovl <= 1'b1;
		run_until(2000);
		chk(32'(n >= BLANK + SPIKE_CYC && n <= BLANK + SPIKE_CYC + 10), 32'h1);
		chk(chg, 0);
		ovl <= 1'b0; tick(2);
		chk(32'(restart), 32'h0);
		$display("basic blanking test ended");
		bus(1, REG_CTRL, 32'h3); bus(1, REG_INT_STATUS, 32'h1F);
		ovl <= 1'b1; tick(BLANK + 4);
		chk(32'(sw), 32'h4);
		chk(32'(restart), 32'h0);
		tick(40); ovl <= 1'b0; tick(2);
		chk(32'(sw), 32'h0);
		bus(0, REG_EXT_COUNT, 0); chk(q, 32'h0);
		ext_ticks <= 10'h003; sel_ticks <= 10'h00F; ovl <= 1'b1;
		run_until(20000);
		chk(chg, 256);
		bus(0, REG_EXT_COUNT, 0); chk(q, 32'(EXT_TOTAL));
		bus(0, REG_INT_STATUS, 0); chk(32'(q[3:2]), 32'h3);
		chk(32'(irq), 32'h0);
		bus(1, REG_INT_MASK, 32'h8); tick(2);
		chk(32'(irq), 32'h1);
		ovl <= 1'b0; tick(2);
		bus(1, REG_INT_STATUS, 32'h8); tick(2);
		chk(32'(irq), 32'h0);
		bus(0, REG_INT_STATUS, 0); chk(32'(q[3:2]), 32'h1);
		$display("extension test ended");
		oth <= 1'b1;
		run_until(BLANK + 20);
		chk(chg, 0);
		oth <= 1'b0; tick(2);
		chk(32'(lvl), 32'(LVL_10));
		$display("other fault test ended");
		test_done();
	end
endmodule
`default_nettype wire
